/* File: core/converter_seq_pkg.sv */
/*
  Constants shared by the converter start-up sequencer: timing, register
  offsets, field positions, reset values and the sequencer state type.
  Assumes a single 10 MHz system clock and a 32-bit classic Wishbone bus.
*/
package converter_seq_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 100; // 10 MHz system clock

  // conversion time after sampling, in picoseconds (longest, rounds down)
  localparam int unsigned CONV_TIME_PS = 62500;
  localparam int unsigned CONV_CYC_RAW = CONV_TIME_PS / (CLK_PERIOD_NS * 1000);
  localparam int unsigned CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;

  // attenuator settling wait (least time, rounds up)
  localparam int unsigned SETTLE_TIME_NS = 1000;
  localparam int unsigned SETTLE_CYC =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // plain sampling phase without attenuator
  localparam int unsigned SAMPLE_CYC = 1;

  // longest programmable delay (rounds down)
  localparam int unsigned DELAY_MAX_NS = 32000;
  localparam int unsigned DELAY_MAX_CYC = DELAY_MAX_NS / CLK_PERIOD_NS;

  // widths
  localparam int unsigned DLY_W = 9;   // delay fields and delay counter
  localparam int unsigned SEQ_W = 8;   // sequencer phase counter
  localparam int unsigned CHAN_W = 4;  // input channel select
  localparam int unsigned ADDR_W = 8;  // byte address bits decoded

  // register byte offsets
  localparam logic [7:0] OFF_MAIN = 8'h00;   // converter_main_control
  localparam logic [7:0] OFF_SECOND = 8'h04; // converter_second_control
  localparam logic [7:0] OFF_DLY1 = 8'h08;   // delay_setting_first
  localparam logic [7:0] OFF_DLY2 = 8'h0c;   // delay_setting_second
  localparam logic [7:0] OFF_STATUS = 8'h10; // status, read only

  // converter_main_control fields
  localparam int unsigned MC_EN_BIT = 0;    // converter_enable_bit
  localparam int unsigned MC_START_BIT = 1; // conversion_start_bit
  localparam int unsigned MC_REG_BIT = 2;   // adc_regulator_enable
  localparam int unsigned MC_MUTE_BIT = 3;  // input_midscale_select
  localparam int unsigned MC_CHAN_LSB = 4;  // channel select
  localparam int unsigned MC_W = 8;

  // converter_second_control fields
  localparam int unsigned SC_DLY_EN_BIT = 0; // delay_counter_enable
  localparam int unsigned SC_ATTN_BIT = 1;   // input_attenuator_select
  localparam int unsigned SC_W = 2;

  // delay field positions
  localparam int unsigned DS_LO_LSB = 0;  // regulator / start delay
  localparam int unsigned DS_HI_LSB = 16; // converter enable delay

  // status fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_REG_BIT = 1;
  localparam int unsigned ST_EN_BIT = 2;
  localparam int unsigned ST_START_BIT = 3;
  localparam int unsigned ST_COUNTING_BIT = 4;
  localparam int unsigned ST_STOPPED_BIT = 5;
  localparam int unsigned ST_ATTN_BIT = 6;
  localparam int unsigned ST_COUNT_LSB = 16;

  // battery channel code
  localparam logic [3:0] CHAN_BATTERY = 4'h3;

  // reset values, staggered: regulator, then enable, then start
  localparam logic [7:0] MC_RST = 8'h00;
  localparam logic [1:0] SC_RST = 2'h0;
  localparam logic [8:0] DLY_REG_RST = 9'h000;
  localparam logic [8:0] DLY_EN_RST = 9'h032;
  localparam logic [8:0] DLY_START_RST = 9'h064;

  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_state_t;

endpackage

/* File: core/conv_seq_if.sv */
/*
  Carrier between the register front end and the conversion sequencer.
  Assumes both ends run on the same clock.
*/
interface conv_seq_if;
  logic go;      // one-cycle launch pulse
  logic atten;   // attenuator engaged for this conversion
  logic busy;    // sequencer not idle
  logic sample;  // sampling phase
  logic convert; // conversion phase
  logic done;    // one-cycle end of conversion

  modport ctrl (output go, output atten,
                input busy, input sample, input convert, input done);
  modport seq (input go, input atten,
               output busy, output sample, output convert, output done);
endinterface

/* File: core/delay_tap.sv */
/*
  One delayed control line: follows its request bit directly, or, with
  the delay counter in use, only once the count reaches its setting.
  Assumes count and setting come from the same clock domain.
*/
module delay_tap #(
  parameter int unsigned W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic request_i,
  input wire logic delay_en_i,
  input wire logic [W-1:0] count_i,
  input wire logic [W-1:0] setting_i,
  output logic fire_o
);

  logic fire_d; // next line level

  // compare count with setting
  always_comb begin
    fire_d = request_i & (~delay_en_i | (count_i >= setting_i));
  end

  // register the line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fire_o <= 1'b0;
    end else begin
      fire_o <= fire_d;
    end
  end

endmodule

/* File: core/conv_sequencer.sv */
/*
  Sampling and conversion phase sequencer. Lengthens the sampling phase
  while the attenuator is engaged and converts in one short phase.
  Assumes go is a one-cycle pulse given only while busy is low.
*/
module conv_sequencer
  import converter_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  conv_seq_if.seq sq
);

  seq_state_t state_q, state_d; // phase
  logic [SEQ_W-1:0] cnt_q, cnt_d; // cycles left in phase
  logic sample_q, sample_d; // sampling switch
  logic convert_q, convert_d; // conversion strobe
  logic done_q, done_d; // end pulse

  // next phase
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sample_d = sample_q;
    convert_d = convert_q;
    done_d = 1'b0;
    unique case (state_q)
      SEQ_IDLE: begin
        if (sq.go) begin
          state_d = SEQ_SAMPLE;
          sample_d = 1'b1;
          // attenuator needs the longer settling wait
          cnt_d = sq.atten ? SEQ_W'(SETTLE_CYC - 1)
                           : SEQ_W'(SAMPLE_CYC - 1);
        end
      end
      SEQ_SAMPLE: begin
        if (cnt_q == '0) begin
          state_d = SEQ_CONVERT;
          sample_d = 1'b0;
          convert_d = 1'b1;
          cnt_d = SEQ_W'(CONV_CYC - 1);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SEQ_CONVERT: begin
        if (cnt_q == '0) begin
          // same short phase with or without attenuator
          state_d = SEQ_IDLE;
          convert_d = 1'b0;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = SEQ_IDLE;
        sample_d = 1'b0;
        convert_d = 1'b0;
      end
    endcase
  end

  // register phase state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SEQ_IDLE;
      cnt_q <= '0;
      sample_q <= 1'b0;
      convert_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sample_q <= sample_d;
      convert_q <= convert_d;
      done_q <= done_d;
    end
  end

  assign sq.busy = (state_q != SEQ_IDLE);
  assign sq.sample = sample_q;
  assign sq.convert = convert_q;
  assign sq.done = done_q;

endmodule

/* File: core/adc_start_delay_sequencer.sv */
/*
  Start-up and conversion control for the general purpose converter:
  Wishbone register file, delay counter, three delayed control lines
  and the attenuator / midscale selection towards the analog macro.
  Assumes a classic Wishbone master on clk_i and an analog macro that
  acts on the registered control outputs.
*/
// Behaviour
// - conversion lasts one short phase after sampling
// - battery channel forces attenuator and settling wait
// - counter delays regulator, enable, start up to 32us
// - delay settings reset to staggered safe order
// - counting begins on start write with enable
// - counter stops when conversion completes
// - clearing counter enable resets the counter
// - midscale select switches input to centre level
module adc_start_delay_sequencer
  import converter_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic regulator_en_o,
  output logic converter_en_o,
  output logic conv_start_o,
  output logic sample_o,
  output logic convert_o,
  output logic conversion_done_o,
  output logic attenuator_o,
  output logic midscale_o,
  output logic [CHAN_W-1:0] channel_o
);

  conv_seq_if sq (); // link to sequencer

  // register state
  logic [MC_W-1:0] main_q, main_d; // converter_main_control
  logic [SC_W-1:0] second_q, second_d; // converter_second_control
  logic [DLY_W-1:0] dly_reg_q, dly_reg_d; // regulator delay
  logic [DLY_W-1:0] dly_en_q, dly_en_d; // converter enable delay
  logic [DLY_W-1:0] dly_start_q, dly_start_d; // start delay
  // delay counter state
  logic [DLY_W-1:0] count_q, count_d; // cycles since start write
  logic counting_q, counting_d; // counter running
  logic stopped_q, stopped_d; // finished, awaiting reset
  logic launched_q, launched_d; // conversion issued for this start
  // bus answer
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  // analog side selects
  logic attn_q, attn_d;
  logic mid_q, mid_d;
  logic [CHAN_W-1:0] chan_q, chan_d;

  // decoded bus request
  logic req; // new request this cycle
  logic wr; // write request
  logic [31:0] wmain; // merged main word
  logic [31:0] wsecond; // merged second word
  logic [31:0] wdly1; // merged first delay word
  logic [31:0] wdly2; // merged second delay word
  logic [MC_W-1:0] main_base; // main after hardware clear
  logic delay_en; // delay_counter_enable level
  logic reg_fire; // delayed regulator line
  logic en_fire; // delayed converter enable line
  logic start_fire; // delayed start line
  logic start_wr; // software writes start = 1

  // byte-lane write merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // limit a programmed delay to the longest allowed
  function automatic logic [DLY_W-1:0] clamp(input logic [DLY_W-1:0] v);
    logic [DLY_W-1:0] lim;
    lim = DLY_W'(DELAY_MAX_CYC);
    return (v > lim) ? lim : v;
  endfunction

  assign delay_en = second_q[SC_DLY_EN_BIT];
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;

  // one tap per delayed line
  delay_tap #(.W(DLY_W)) u_tap_reg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .request_i(main_q[MC_REG_BIT]),
    .delay_en_i(delay_en),
    .count_i(count_q),
    .setting_i(dly_reg_q),
    .fire_o(reg_fire)
  );

  delay_tap #(.W(DLY_W)) u_tap_en (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .request_i(main_q[MC_EN_BIT]),
    .delay_en_i(delay_en),
    .count_i(count_q),
    .setting_i(dly_en_q),
    .fire_o(en_fire)
  );

  delay_tap #(.W(DLY_W)) u_tap_start (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .request_i(main_q[MC_START_BIT] & ~launched_q),
    .delay_en_i(delay_en),
    .count_i(count_q),
    .setting_i(dly_start_q),
    .fire_o(start_fire)
  );

  conv_sequencer u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sq(sq)
  );

  // launch once the delayed start and enable are both up
  assign sq.go = start_fire & en_fire & ~launched_q & ~sq.busy;
  assign sq.atten = attn_q;

  // control registers and delay counter
  always_comb begin
    // start bit clears when its conversion ends; a write can set it again
    main_base = main_q;
    if (sq.done) begin
      main_base[MC_START_BIT] = 1'b0;
    end
    wmain = merge({{(32-MC_W){1'b0}}, main_base}, wb_dat_i, wb_sel_i);
    wsecond = merge({{(32-SC_W){1'b0}}, second_q}, wb_dat_i, wb_sel_i);
    wdly1 = merge({7'h00, dly_en_q, 7'h00, dly_reg_q}, wb_dat_i, wb_sel_i);
    wdly2 = merge({23'h000000, dly_start_q}, wb_dat_i, wb_sel_i);
    main_d = main_base;
    second_d = second_q;
    dly_reg_d = dly_reg_q;
    dly_en_d = dly_en_q;
    dly_start_d = dly_start_q;
    start_wr = 1'b0;
    if (wr) begin
      unique case (wb_adr_i)
        OFF_MAIN: begin
          main_d = wmain[MC_W-1:0];
          start_wr = wmain[MC_START_BIT] & wb_sel_i[0];
        end
        OFF_SECOND: second_d = wsecond[SC_W-1:0];
        OFF_DLY1: begin
          dly_reg_d = clamp(wdly1[DS_LO_LSB +: DLY_W]);
          dly_en_d = clamp(wdly1[DS_HI_LSB +: DLY_W]);
        end
        OFF_DLY2: dly_start_d = clamp(wdly2[DS_LO_LSB +: DLY_W]);
        default: main_d = main_base; // unmapped or read only
      endcase
    end

    // delay counter
    count_d = count_q;
    counting_d = counting_q;
    stopped_d = stopped_q;
    if (counting_q && count_q != {DLY_W{1'b1}}) begin
      count_d = count_q + 1'b1;
    end
    if (start_wr && delay_en && !counting_q && !stopped_q) begin
      counting_d = 1'b1;
    end
    if (sq.done && counting_q) begin
      counting_d = 1'b0;
      stopped_d = 1'b1;
      count_d = count_q;
    end
    if (!second_d[SC_DLY_EN_BIT]) begin
      count_d = '0;
      counting_d = 1'b0;
      stopped_d = 1'b0;
    end

    // one conversion per start bit
    launched_d = launched_q;
    if (sq.go) begin
      launched_d = 1'b1;
    end
    if (sq.done) begin
      launched_d = 1'b0;
    end

    // analog side selects
    attn_d = second_q[SC_ATTN_BIT] |
             (main_q[MC_CHAN_LSB +: CHAN_W] == CHAN_BATTERY);
    mid_d = main_q[MC_MUTE_BIT];
    chan_d = main_q[MC_CHAN_LSB +: CHAN_W];
  end

  // bus answer and read data
  always_comb begin
    ack_d = req; // one answer per request, dropped next cycle
    rdata_d = '0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        OFF_MAIN: rdata_d[MC_W-1:0] = main_q;
        OFF_SECOND: rdata_d[SC_W-1:0] = second_q;
        OFF_DLY1: begin
          rdata_d[DS_LO_LSB +: DLY_W] = dly_reg_q;
          rdata_d[DS_HI_LSB +: DLY_W] = dly_en_q;
        end
        OFF_DLY2: rdata_d[DS_LO_LSB +: DLY_W] = dly_start_q;
        OFF_STATUS: begin
          rdata_d[ST_BUSY_BIT] = sq.busy;
          rdata_d[ST_REG_BIT] = reg_fire;
          rdata_d[ST_EN_BIT] = en_fire;
          rdata_d[ST_START_BIT] = start_fire;
          rdata_d[ST_COUNTING_BIT] = counting_q;
          rdata_d[ST_STOPPED_BIT] = stopped_q;
          rdata_d[ST_ATTN_BIT] = attn_q;
          rdata_d[ST_COUNT_LSB +: DLY_W] = count_q;
        end
        default: rdata_d = '0; // unmapped reads zero
      endcase
    end
  end

  // register everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_q <= MC_RST;
      second_q <= SC_RST;
      dly_reg_q <= DLY_REG_RST;
      dly_en_q <= DLY_EN_RST;
      dly_start_q <= DLY_START_RST;
      count_q <= '0;
      counting_q <= 1'b0;
      stopped_q <= 1'b0;
      launched_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= '0;
      attn_q <= 1'b0;
      mid_q <= 1'b0;
      chan_q <= '0;
    end else begin
      main_q <= main_d;
      second_q <= second_d;
      dly_reg_q <= dly_reg_d;
      dly_en_q <= dly_en_d;
      dly_start_q <= dly_start_d;
      count_q <= count_d;
      counting_q <= counting_d;
      stopped_q <= stopped_d;
      launched_q <= launched_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      attn_q <= attn_d;
      mid_q <= mid_d;
      chan_q <= chan_d;
    end
  end

  // outputs, all from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign regulator_en_o = reg_fire;
  assign converter_en_o = en_fire;
  assign conv_start_o = start_fire;
  assign sample_o = sq.sample;
  assign convert_o = sq.convert;
  assign conversion_done_o = sq.done;
  assign attenuator_o = attn_q;
  assign midscale_o = mid_q;
  assign channel_o = chan_q;

endmodule

/* File: testbench/adc_start_delay_sequencer_chk.sv */
/*
  Port-level checker for the converter start-up sequencer.
  Assumes one clock, synchronous active-high reset, bound to the top.
*/
module adc_start_delay_sequencer_chk
  import converter_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic regulator_en_o,
  input wire logic converter_en_o,
  input wire logic conv_start_o,
  input wire logic sample_o,
  input wire logic convert_o,
  input wire logic conversion_done_o,
  input wire logic attenuator_o,
  input wire logic midscale_o,
  input wire logic [CHAN_W-1:0] channel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a write taken into the main control register
  sequence main_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
      wb_adr_i == OFF_MAIN && wb_sel_i[0];
  endsequence
  // bus answers once, one cycle after the request
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("ack missing");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // conversion is one short phase then done
  conv_short_a: assert property (convert_o |=> !convert_o &&
    conversion_done_o) else $error("conversion not one cycle");
  done_pulse_a: assert property (conversion_done_o |=> !conversion_done_o)
    else $error("done too long");
  // sampling length with and without attenuator
  settle_long_a: assert property ($rose(sample_o) && attenuator_o |->
    sample_o [*8] ##1 sample_o [*2] ##1 (!sample_o && convert_o))
    else $error("attenuated sampling not ten cycles");
  sample_short_a: assert property ($rose(sample_o) && !attenuator_o |=>
    !sample_o && convert_o) else $error("plain sampling not one cycle");
  battery_attn_a: assert property (channel_o == CHAN_BATTERY |->
    attenuator_o) else $error("battery channel without attenuator");
  mute_follow_a: assert property (main_wr |-> ##2
    midscale_o == $past(wb_dat_i[MC_MUTE_BIT], 2))
    else $error("midscale does not follow register");
  chan_follow_a: assert property (main_wr |-> ##2
    channel_o == $past(wb_dat_i[MC_CHAN_LSB +: CHAN_W], 2))
    else $error("channel does not follow register");
  cover property (conversion_done_o && attenuator_o);
  cover property (conversion_done_o && !attenuator_o);
  cover property (main_wr);
endmodule

bind adc_start_delay_sequencer adc_start_delay_sequencer_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .regulator_en_o(regulator_en_o), .converter_en_o(converter_en_o),
  .conv_start_o(conv_start_o), .sample_o(sample_o),
  .convert_o(convert_o), .conversion_done_o(conversion_done_o),
  .attenuator_o(attenuator_o), .midscale_o(midscale_o),
  .channel_o(channel_o));

/* File: testbench/adc_start_delay_sequencer_bench.sv */
/*
  Self-checking bench for the converter start-up sequencer.
  Assumes the checker file is compiled alongside and binds itself.
*/
module adc_start_delay_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import converter_seq_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, reg_en, conv_en, start, smp, cnv, done, attn, mid;
  logic [3:0] chan;
  int errors = 0, comparisons = 0;

  adc_start_delay_sequencer DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .regulator_en_o(reg_en), .converter_en_o(conv_en),
    .conv_start_o(start), .sample_o(smp), .convert_o(cnv),
    .conversion_done_o(done), .attenuator_o(attn), .midscale_o(mid),
    .channel_o(chan));

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, held until ack, then a cycle idle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      errors++;
      close_out();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] m, exp);
    bus(1'b0, a, 32'h0, q);
    check(what, q & m, exp);
  endtask

  // bounded wait for end of conversion
  task automatic wait_done();
    int n;
    for (n = 0; n < 1000 && done !== 1'b1; n++) @(posedge clk);
    if (done !== 1'b1) begin
      errors++;
      close_out();
    end
    @(posedge clk);
  endtask

  task automatic t_reset();
    // every control output low straight after reset
    check("reset outputs", {reg_en, conv_en, start, smp, cnv, done, attn,
      mid, chan}, 32'h0);
    rd_chk("main", OFF_MAIN, '1, 32'h0);
    rd_chk("second", OFF_SECOND, '1, 32'h0);
    rd_chk("dly1", OFF_DLY1, '1, {7'h0, DLY_EN_RST, 7'h0, DLY_REG_RST});
    rd_chk("dly2", OFF_DLY2, '1, {23'h0, DLY_START_RST});
    wr(8'h20, 32'hffff_ffff);
    rd_chk("unmapped", 8'h20, '1, 32'h0);
    wr(OFF_DLY2, 32'h0000_01ff);
    rd_chk("clamp", OFF_DLY2, '1, 32'h0000_0140);
  endtask

  task automatic t_plain();
    // regulator, then enable, then start: each write keeps the earlier bits set
    wr(OFF_MAIN, 32'h04);
    wr(OFF_MAIN, 32'h05);
    wr(OFF_MAIN, 32'h07);
    wait_done();
    rd_chk("status plain", OFF_STATUS, '1, 32'h6);
    wr(OFF_STATUS, 32'hffff_ffff);
    rd_chk("status ro", OFF_STATUS, '1, 32'h6);
    wr(OFF_MAIN, 32'h00);
  endtask

  task automatic t_delay();
    int k, tr, te, ts;
    logic [31:0] w;
    tr = -1;
    te = -1;
    ts = -1;
    wr(OFF_DLY1, 32'h0014_0005);
    wr(OFF_DLY2, 32'h0000_0028);
    rd_chk("enable clear", OFF_SECOND, '1, 32'h0);
    wr(OFF_SECOND, 32'h1);
    wr(OFF_MAIN, 32'h07);
    for (k = 0; k < 600 && done !== 1'b1; k++) begin
      @(posedge clk);
      if (tr < 0 && reg_en === 1'b1) tr = k;
      if (te < 0 && conv_en === 1'b1) te = k;
      if (ts < 0 && start === 1'b1) ts = k;
    end
    check("enable lag", te - tr, 32'd15);
    check("start lag", ts - tr, 32'd35);
    wait_done();
    rd_chk("stopped", OFF_STATUS, 32'hff, 32'h26);
    // counter must hold its value once the conversion is over
    w = q;
    repeat (5) @(posedge clk);
    rd_chk("count held", OFF_STATUS, 32'h01ff_0000, w & 32'h01ff_0000);
    check("count ran", w[ST_COUNT_LSB +: DLY_W] >= 9'h028, 1'b1);
    wr(OFF_SECOND, 32'h0);
    rd_chk("cleared", OFF_STATUS, '1, 32'h6);
    wr(OFF_MAIN, 32'h00);
  endtask

  task automatic t_attn();
    // channel first, settle, then start
    wr(OFF_MAIN, {24'h0, CHAN_BATTERY, 4'h5});
    repeat (SETTLE_CYC) @(posedge clk);
    wr(OFF_MAIN, {24'h0, CHAN_BATTERY, 4'h7});
    wait_done();
    check("battery attn", attn, 1'b1);
    check("battery chan", chan, CHAN_BATTERY);
    wr(OFF_MAIN, 32'h00);
    wr(OFF_SECOND, 32'h2);
    wr(OFF_MAIN, 32'h15);
    repeat (SETTLE_CYC) @(posedge clk);
    wr(OFF_MAIN, 32'h17);
    wait_done();
    check("attn bit", attn, 1'b1);
    wr(OFF_SECOND, 32'h0);
    wr(OFF_MAIN, 32'h08);
    @(posedge clk);
    check("midscale", mid, 1'b1);
    check("attn off", attn, 1'b0);
  endtask

  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_plain();
    t_delay();
    t_attn();
    close_out();
  end
endmodule
